// ---- verilog/nvm_pkg.sv ----
// Purpose: shared constants for the nonvolatile self-access controller
// Assumes: 250 MHz aclk, AXI4-Lite with 32-bit data, 8-bit addresses
// Notes: register data sits in bits 7:0, upper bits read as zero
package nvm_pkg;

  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned ERASE_TIME_US = 2000;
  localparam int unsigned ERASE_CYC = ERASE_TIME_US * CLK_MHZ;
  localparam int unsigned TMR_W = 20;

  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_KEY = 8'h04;
  localparam logic [7:0] A_ADRL = 8'h08;
  localparam logic [7:0] A_ADRH = 8'h0c;
  localparam logic [7:0] A_DATL = 8'h10;
  localparam logic [7:0] A_DATH = 8'h14;
  localparam logic [7:0] A_STAT = 8'h18;

  localparam int unsigned CTL_RD = 0;
  localparam int unsigned CTL_WR = 1;
  localparam int unsigned CTL_PERMIT = 2;
  localparam int unsigned CTL_ABORT = 3;
  localparam int unsigned CTL_ROWER = 4;
  localparam int unsigned CTL_PGD = 7;
  localparam int unsigned ST_DONE = 0;
  localparam int unsigned ST_BUSY = 1;

  localparam logic [7:0] KEY1 = 8'h55;
  localparam logic [7:0] KEY2 = 8'haa;

  localparam int unsigned ADRH_W = 5;
  localparam int unsigned DATH_W = 6;
  localparam int unsigned WORD_W = 14;
  localparam int unsigned PADDR_W = 13;
  localparam int unsigned ROW_LSB = 5;
  localparam logic [1:0] SETUP_LAST = 2'h1;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD_WAIT = 3'b001,
    ST_RD_ACC = 3'b010,
    ST_RD_LATCH = 3'b011,
    ST_EE_WR = 3'b100,
    ST_ER_SETUP = 3'b101,
    ST_ER_RUN = 3'b110
  } state_t;

endpackage

// ---- verilog/nvm_timer.sv ----
// Purpose: down-counter that times a write or erase cycle
// Assumes: load and stop come from logic on aclk
// Notes: done pulses exactly cycles-1 edges after the load edge
`timescale 1ns/100ps
module nvm_timer
  import nvm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic load,
  input wire logic stop,
  input wire logic [TMR_W-1:0] cycles,
  output logic done
);

  logic [TMR_W-1:0] cnt_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else if (stop) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= cycles;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign done = (cnt_q == TMR_W'(1)) && !stop;

endmodule

// ---- verilog/nvm_unlock.sv ----
// Purpose: two-key unlock sequencer guarding write and erase triggers
// Assumes: strobes are single-cycle register write events
// Notes: armed lasts only until the next register write, unless that write is to the key register with wstrb[0] low
`timescale 1ns/100ps
module nvm_unlock
  import nvm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic key_wr,
  input wire logic [7:0] key_val,
  input wire logic other_wr,
  output logic armed
);

  logic got1_q;
  logic armed_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      got1_q <= 1'b0;
      armed_q <= 1'b0;
    end else if (key_wr) begin
      got1_q <= (key_val == KEY1);
      armed_q <= got1_q && (key_val == KEY2);
    end else if (other_wr) begin
      got1_q <= 1'b0;
      armed_q <= 1'b0;
    end
  end

  assign armed = armed_q;

endmodule

// ---- verilog/nvm_self_access.sv ----
// Purpose: EEPROM byte write, Flash word read and Flash row erase control
// Assumes: array macro answers a read one cycle after mem_rd_en
// Notes: warm_rst_pin models an external or watchdog reset of the core
`timescale 1ns/100ps
module nvm_self_access
  import nvm_pkg::*;
#(
  parameter int unsigned EE_WRITE_CYC = ERASE_CYC,
  parameter int unsigned ERASE_RUN_CYC = ERASE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [PADDR_W-1:0] mem_addr,
  output logic mem_rd_en,
  input wire logic [WORD_W-1:0] mem_rdata,
  output logic ee_wr_en,
  output logic [7:0] ee_data,
  output logic erase_en,
  output logic cpu_stall,
  output logic insn_skip,
  input wire logic warm_rst_pin
);

  state_t state_q;
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] araddr_q;
  logic pgd_q;
  logic rower_q;
  logic permit_q;
  logic abort_q;
  logic wr_q;
  logic rd_q;
  logic done_q;
  logic [7:0] adrl_q;
  logic [ADRH_W-1:0] adrh_q;
  logic [7:0] datl_q;
  logic [DATH_W-1:0] dath_q;
  logic [1:0] setup_q;
  logic tmr_load_q;
  logic warm_s1_q;
  logic warm_s2_q;
  logic wr_fire;
  logic wr_en;
  logic ctrl_wr;
  logic armed;
  logic trig_ok;
  logic rd_ok;
  logic abort_evt;
  logic complete;
  logic tmr_done;
  logic setup_last;
  logic [7:0] ctrl_rd;
  logic [7:0] rd_mux;
  logic [TMR_W-1:0] tmr_cycles;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == A_CTRL) || (a == A_KEY) || (a == A_ADRL) ||
             (a == A_ADRH) || (a == A_DATL) || (a == A_DATH) ||
             (a == A_STAT);
  endfunction

  // AXI4-Lite write side: address and data may arrive in either order
  assign awready = !aw_have_q;
  assign wready = !w_have_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign wr_en = wr_fire && wstrb0_q;
  assign ctrl_wr = wr_en && (awaddr_q == A_CTRL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (awvalid && awready) begin
      aw_have_q <= 1'b1;
      awaddr_q <= awaddr;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else if (wvalid && wready) begin
      w_have_q <= 1'b1;
      wdata_q <= wdata[7:0];
      wstrb0_q <= wstrb[0];
    end else if (wr_fire) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read side answers one cycle after the address is taken
  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[CTL_PGD] = pgd_q;
    ctrl_rd[CTL_ROWER] = rower_q;
    ctrl_rd[CTL_ABORT] = abort_q;
    ctrl_rd[CTL_PERMIT] = permit_q;
    ctrl_rd[CTL_WR] = wr_q;
    ctrl_rd[CTL_RD] = rd_q;
  end

  always_comb begin
    rd_mux = 8'h00;
    case (araddr)
      A_CTRL: rd_mux = ctrl_rd;
      A_KEY: rd_mux = 8'h00;
      A_ADRL: rd_mux = adrl_q;
      A_ADRH: rd_mux = {{(8-ADRH_W){1'b0}}, adrh_q};
      A_DATL: rd_mux = datl_q;
      A_DATH: rd_mux = {{(8-DATH_W){1'b0}}, dath_q};
      A_STAT: begin
        rd_mux[ST_DONE] = done_q;
        rd_mux[ST_BUSY] = wr_q;
      end
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
      araddr_q <= 8'h00;
    end else if (arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h00_0000, rd_mux};
      rresp_q <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      araddr_q <= araddr;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Core reset pin is asynchronous to aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      warm_s1_q <= 1'b0;
      warm_s2_q <= 1'b0;
    end else begin
      warm_s1_q <= warm_rst_pin;
      warm_s2_q <= warm_s1_q;
    end
  end

  nvm_unlock u_unlock (
    .aclk(aclk),
    .aresetn(aresetn),
    .key_wr(wr_en && (awaddr_q == A_KEY)),
    .key_val(wdata_q),
    .other_wr(wr_fire && (awaddr_q != A_KEY)),
    .armed(armed)
  );

  // Space select and row erase are taken as they stood before this write
  assign trig_ok = ctrl_wr && wdata_q[CTL_WR] && !wr_q &&
                   (state_q == ST_IDLE) && permit_q &&
                   armed && (!pgd_q || rower_q);
  assign rd_ok = ctrl_wr && wdata_q[CTL_RD] && !trig_ok &&
                 (state_q == ST_IDLE) && pgd_q;
  assign abort_evt = warm_s2_q && wr_q;
  assign complete = tmr_done && !abort_evt &&
                    ((state_q == ST_EE_WR) || (state_q == ST_ER_RUN));
  assign setup_last = (setup_q == SETUP_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_IDLE;
    end else if (abort_evt) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (trig_ok) begin
            state_q <= pgd_q ? ST_ER_SETUP : ST_EE_WR;
          end else if (rd_ok) begin
            state_q <= ST_RD_WAIT;
          end
        end
        ST_RD_WAIT: state_q <= ST_RD_ACC;
        ST_RD_ACC: state_q <= ST_RD_LATCH;
        ST_RD_LATCH: state_q <= ST_IDLE;
        ST_EE_WR: begin
          if (complete) begin
            state_q <= ST_IDLE;
          end
        end
        ST_ER_SETUP: begin
          if (setup_last) begin
            state_q <= ST_ER_RUN;
          end
        end
        ST_ER_RUN: begin
          if (complete) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setup_q <= 2'h0;
    end else if (state_q == ST_ER_SETUP) begin
      setup_q <= setup_q + 2'h1;
    end else begin
      setup_q <= 2'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmr_load_q <= 1'b0;
    end else begin
      tmr_load_q <= !abort_evt &&
        ((trig_ok && !pgd_q) ||
         ((state_q == ST_ER_SETUP) && setup_last));
    end
  end

  assign tmr_cycles = (state_q == ST_ER_RUN) ?
                      TMR_W'(ERASE_RUN_CYC) : TMR_W'(EE_WRITE_CYC);

  nvm_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .load(tmr_load_q),
    .stop(abort_evt),
    .cycles(tmr_cycles),
    .done(tmr_done)
  );

  // Trigger bits ignore software clears; a set lost to a busy block stays 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q <= 1'b0;
    end else if (complete || abort_evt) begin
      wr_q <= 1'b0;
    end else if (trig_ok) begin
      wr_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_q <= 1'b0;
    end else if (state_q == ST_RD_LATCH) begin
      rd_q <= 1'b0;
    end else if (rd_ok) begin
      rd_q <= 1'b1;
    end
  end

  // Permit only follows software, so it cannot cut a running cycle short
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      permit_q <= 1'b0;
      rower_q <= 1'b0;
    end else if (ctrl_wr) begin
      permit_q <= wdata_q[CTL_PERMIT];
      rower_q <= wdata_q[CTL_ROWER];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pgd_q <= 1'b0;
    end else if (ctrl_wr && !wr_q) begin
      pgd_q <= wdata_q[CTL_PGD];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      abort_q <= 1'b0;
    end else if (abort_evt) begin
      abort_q <= 1'b1;
    end else if (ctrl_wr) begin
      abort_q <= wdata_q[CTL_ABORT];
    end
  end

  // Set wins over a same-cycle write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_q <= 1'b0;
    end else if (complete) begin
      done_q <= 1'b1;
    end else if (wr_en && (awaddr_q == A_STAT) && wdata_q[ST_DONE]) begin
      done_q <= 1'b0;
    end
  end

  // Address is never touched by hardware, so an abort leaves it intact
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adrl_q <= 8'h00;
      adrh_q <= '0;
    end else if (wr_en && (awaddr_q == A_ADRL)) begin
      adrl_q <= wdata_q;
    end else if (wr_en && (awaddr_q == A_ADRH)) begin
      adrh_q <= wdata_q[ADRH_W-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      datl_q <= 8'h00;
      dath_q <= '0;
    end else if (state_q == ST_RD_LATCH) begin
      datl_q <= mem_rdata[7:0];
      dath_q <= mem_rdata[WORD_W-1:8];
    end else if (wr_en && (awaddr_q == A_DATL)) begin
      datl_q <= wdata_q;
    end else if (wr_en && (awaddr_q == A_DATH)) begin
      dath_q <= wdata_q[DATH_W-1:0];
    end
  end

  always_comb begin
    if (state_q == ST_ER_RUN) begin
      mem_addr = {adrh_q, adrl_q[7:ROW_LSB], {ROW_LSB{1'b0}}};
    end else if (state_q == ST_EE_WR) begin
      mem_addr = {{ADRH_W{1'b0}}, adrl_q};
    end else begin
      mem_addr = {adrh_q, adrl_q};
    end
  end

  assign mem_rd_en = (state_q == ST_RD_ACC);
  assign ee_wr_en = tmr_load_q && (state_q == ST_EE_WR);
  assign erase_en = tmr_load_q && (state_q == ST_ER_RUN);
  assign ee_data = datl_q;
  assign cpu_stall = (state_q == ST_ER_RUN);
  assign insn_skip = (state_q == ST_RD_ACC) ||
                     (state_q == ST_ER_SETUP);

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_key_zero;
    rvalid && (araddr_q == A_KEY) |-> rdata == 32'h0000_0000;
  endproperty
  a_key_zero: assert property (p_key_zero)
    else $error("key port read not zero");

  property p_trig_permit;
    $rose(wr_q) |-> $past(permit_q) && $past(ctrl_wr);
  endproperty
  a_trig_permit: assert property (p_trig_permit)
    else $error("trigger set without permit");

  property p_permit_hold;
    $fell(permit_q) |-> $past(ctrl_wr);
  endproperty
  a_permit_hold: assert property (p_permit_hold)
    else $error("permit cleared by hardware");

  property p_done_set;
    complete |=> done_q && !wr_q;
  endproperty
  a_done_set: assert property (p_done_set)
    else $error("completion did not set flag and clear trigger");

  property p_done_sticky;
    done_q && !(wr_en && (awaddr_q == A_STAT)) |=> done_q;
  endproperty
  a_done_sticky: assert property (p_done_sticky)
    else $error("done flag dropped without software");

  property p_run_on;
    wr_q && !complete && !abort_evt |=> wr_q;
  endproperty
  a_run_on: assert property (p_run_on)
    else $error("write cycle ended early");

  property p_rd_slot;
    $rose(rd_q) |-> ##1 mem_rd_en ##2
      (!rd_q && (datl_q == $past(mem_rdata[7:0], 1)));
  endproperty
  a_rd_slot: assert property (p_rd_slot)
    else $error("flash read slot or result wrong");

  property p_erase_setup;
    $rose(state_q == ST_ER_SETUP) |->
      !cpu_stall [*2] ##1 (cpu_stall && erase_en);
  endproperty
  a_erase_setup: assert property (p_erase_setup)
    else $error("erase setup not two cycles");

  property p_erase_addr;
    erase_en |-> mem_addr[ROW_LSB-1:0] == '0;
  endproperty
  a_erase_addr: assert property (p_erase_addr)
    else $error("erase address low bits not ignored");

  property p_abort;
    abort_evt |=> abort_q && !wr_q && !cpu_stall;
  endproperty
  a_abort: assert property (p_abort)
    else $error("abort not flagged");

endmodule

// ---- verification/nvm_array_model.sv ----
// Purpose: program array stand-in answering read strobes of the controller
// Assumes: word is due the cycle after mem_rd_en, as the controller expects
// Notes: contents are a fixed function of the address, known to the bench
`timescale 1ns/100ps
module nvm_array_model
  import nvm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mem_rd_en,
  input wire logic [PADDR_W-1:0] mem_addr,
  output logic [WORD_W-1:0] mem_rdata
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_rdata <= 14'h0000;
    end else if (mem_rd_en) begin
      mem_rdata <= {1'b1, mem_addr} ^ 14'h2a5c;
    end else begin
      // Word is not held, so a late sample shows a wrong value
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// ---- verification/test_nvm_self_access.sv ----
// Purpose: self-checking bench for the self-access controller
// Assumes: AXI4-Lite master in tasks, array model on the far side
// Notes: write and erase times shortened through the parameters
`timescale 1ns/100ps
module test_nvm_self_access
  import nvm_pkg::*;
;
  localparam int EW = 20;
  localparam int ER = 30;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, warm_rst_pin = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, mem_rd_en, ee_wr_en;
  logic erase_en, cpu_stall, insn_skip;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, v;
  logic [12:0] mem_addr, ee_addr, er_addr, rd_addr;
  logic [13:0] mem_rdata, w14;
  logic [7:0] ee_data, ee_dat;
  int bad_count = 0, checked = 0, n_ee, n_er, n_stall, n_skip;

  nvm_self_access #(.EE_WRITE_CYC(EW), .ERASE_RUN_CYC(ER)) u_nvm_self_access (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .mem_addr(mem_addr),
    .mem_rd_en(mem_rd_en), .mem_rdata(mem_rdata), .ee_wr_en(ee_wr_en),
    .ee_data(ee_data), .erase_en(erase_en), .cpu_stall(cpu_stall),
    .insn_skip(insn_skip), .warm_rst_pin(warm_rst_pin));
  nvm_array_model u_nvm_array_model (.aclk(aclk), .aresetn(aresetn),
    .mem_rd_en(mem_rd_en), .mem_addr(mem_addr), .mem_rdata(mem_rdata));

  initial begin
    forever #2 aclk = ~aclk;
  end

  // Event monitor on the array and core sides
  always @(posedge aclk) begin
    if (ee_wr_en === 1'b1) begin
      n_ee++;
      ee_addr = mem_addr;
      ee_dat = ee_data;
    end
    if (erase_en === 1'b1) begin
      n_er++;
      er_addr = mem_addr;
    end
    if (mem_rd_en === 1'b1) rd_addr = mem_addr;
    if (cpu_stall === 1'b1) n_stall++;
    if (insn_skip === 1'b1) n_skip++;
  end

  task results;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stuck();
    bad_count++;
    $display("Error at %0t: got %h expected %h", $time, 0, 1);
    results();
  endtask

  task automatic axw(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er);
    int n;
    bit got;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    got = 0;
    n = 0;
    while (!got) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        got = 1;
      end
      if (n > 100) stuck();
    end
  endtask

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    axw(a, d, RESP_OKAY);
  endtask

  task automatic axr(input logic [7:0] a, input logic [1:0] er,
                     output logic [31:0] d);
    int n;
    bit got;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    got = 0;
    n = 0;
    while (!got) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        chk({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
        got = 1;
      end
      if (n > 100) stuck();
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    axr(a, RESP_OKAY, v);
    chk(v, exp);
  endtask

  // Keys go out back to back, as firmware does with interrupts masked
  task automatic key();
    w(A_KEY, KEY1);
    w(A_KEY, KEY2);
  endtask

  task automatic clr();
    n_ee = 0;
    n_er = 0;
    n_stall = 0;
    n_skip = 0;
  endtask

  // Polls busy, as firmware must before the next write
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      axr(A_STAT, RESP_OKAY, v);
      n++;
      if (n > 200) stuck();
    end while (v[ST_BUSY] !== 1'b0);
  endtask

  task automatic t_reset();
    for (int i = 0; i < 7; i++) begin
      rc(8'(i * 4), 32'h0);
    end
    axr(8'h1c, RESP_SLVERR, v);
    axw(8'h1c, 8'hff, RESP_SLVERR);
    $display("test reset done");
  endtask

  task automatic t_ee_write();
    clr();
    w(A_ADRL, 8'h3c);
    w(A_DATL, 8'h96);
    w(A_CTRL, 8'h04);
    key();
    w(A_CTRL, 8'h06);
    rc(A_STAT, 32'h2);
    wait_idle();
    chk(n_ee, 1);
    chk(ee_addr, 13'h003c);
    chk(ee_dat, 8'h96);
    rc(A_CTRL, 32'h04);
    w(A_ADRL, 8'h00);
    rc(A_STAT, 32'h1);
    w(A_STAT, 8'h01);
    rc(A_STAT, 32'h0);
    $display("test eeprom write done");
  endtask

  task automatic t_refuse();
    clr();
    w(A_CTRL, 8'h00);
    key();
    w(A_CTRL, 8'h02);
    rc(A_CTRL, 32'h0);
    w(A_CTRL, 8'h04);
    w(A_KEY, KEY2);
    w(A_KEY, KEY1);
    w(A_CTRL, 8'h06);
    rc(A_CTRL, 32'h04);
    w(A_KEY, KEY1);
    w(A_ADRL, 8'h01);
    w(A_KEY, KEY2);
    w(A_CTRL, 8'h06);
    rc(A_CTRL, 32'h04);
    w(A_CTRL, 8'h84);
    key();
    w(A_CTRL, 8'h86);
    rc(A_CTRL, 32'h84);
    chk(n_ee + n_er, 0);
    w(A_CTRL, 8'h00);
    $display("test refusals done");
  endtask

  task automatic t_permit_drop();
    clr();
    w(A_CTRL, 8'h04);
    key();
    w(A_CTRL, 8'h06);
    w(A_CTRL, 8'h00);
    rc(A_STAT, 32'h2);
    wait_idle();
    chk(n_ee, 1);
    rc(A_STAT, 32'h1);
    w(A_STAT, 8'h01);
    $display("test permit drop done");
  endtask

  task automatic t_flash_read();
    clr();
    w(A_ADRH, 8'h15);
    w(A_ADRL, 8'ha7);
    // Space select must already stand before the read trigger is set
    w(A_CTRL, 8'h80);
    w(A_CTRL, 8'h81);
    repeat (4) @(posedge aclk);
    w14 = {1'b1, 13'h15a7} ^ 14'h2a5c;
    rc(A_CTRL, 32'h80);
    chk(rd_addr, 13'h15a7);
    chk(n_skip, 1);
    rc(A_DATL, {24'h0, w14[7:0]});
    rc(A_DATH, {26'h0, w14[13:8]});
    w(A_ADRL, 8'h00);
    rc(A_DATL, {24'h0, w14[7:0]});
    w(A_CTRL, 8'h00);
    $display("test flash read done");
  endtask

  task automatic t_erase();
    clr();
    w(A_ADRH, 8'h0b);
    w(A_ADRL, 8'h5f);
    w(A_CTRL, 8'h94);
    key();
    w(A_CTRL, 8'h96);
    wait_idle();
    chk(n_er, 1);
    chk(er_addr, 13'h0b40);
    chk(n_skip, 2);
    // Stall also covers the cycle in which the timer is loaded
    chk(n_stall, ER + 1);
    rc(A_STAT, 32'h1);
    w(A_STAT, 8'h01);
    w(A_CTRL, 8'h00);
    $display("test row erase done");
  endtask

  task automatic t_abort();
    w(A_ADRL, 8'h77);
    w(A_DATL, 8'h5a);
    w(A_CTRL, 8'h04);
    key();
    w(A_CTRL, 8'h06);
    warm_rst_pin <= 1'b1;
    repeat (3) @(posedge aclk);
    warm_rst_pin <= 1'b0;
    repeat (4) @(posedge aclk);
    axr(A_CTRL, RESP_OKAY, v);
    chk(v & 32'h0a, 32'h08);
    rc(A_ADRL, 32'h77);
    rc(A_DATL, 32'h5a);
    w(A_CTRL, 8'h00);
    $display("test abort done");
  endtask

  initial begin
    clr();
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_ee_write();
    t_refuse();
    t_permit_drop();
    t_flash_read();
    t_erase();
    t_abort();
    results();
  end
endmodule
